// file: hw/fis_regs.svh
`ifndef FIS_REGS_SVH
`define FIS_REGS_SVH

// Opcodes
`define FIS_OP_QUAD_ID 8'haf
`define FIS_OP_ID3 8'h9f
`define FIS_OP_SIG 8'hab
`define FIS_OP_MAKER 8'h90

// Status byte fields
`define FIS_SR_BUSY 0
`define FIS_SR_LATCH 1
`define FIS_SR_BP_LO 2
`define FIS_SR_BP_HI 5
`define FIS_SR_QUAD 6
`define FIS_SR_LOCK 7
`define FIS_SR_RESET 8'h00

// Link clock counts
`define FIS_SPI_CMD_CLKS 5'd8
`define FIS_QUAD_CMD_CLKS 5'd2
`define FIS_SPI_SKIP_CLKS 5'd24
`define FIS_QUAD_SKIP_CLKS 5'd6

`endif

// file: hw/fis_pkg.sv
package fis_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_SKIP,
        ST_OUT,
        ST_DROP
    } fis_state_t;

    typedef enum logic [2:0] {
        SRC_ID3,
        SRC_SIG,
        SRC_MAKER,
        SRC_STATUS,
        SRC_CONFIG
    } fis_src_t;

endpackage : fis_pkg

// file: hw/fis_sync.sv
module fis_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] d_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;

    always_comb
    begin
        meta_next = d_in;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= meta_reg;
        end
    end

    assign d_out = sync_reg;
endmodule : fis_sync

// file: hw/fis_top.sv
// How it works
// - Quad ID bytes follow command, repeat till deselect
// - Decode 9F, AB, 90 and AF reads
// - Status read accepted even while busy
// - Status byte shifted out, one or four lines
// - Config read accepted anytime, either format
// - Busy flag high during program, erase, write
// - Program or erase ignored without write enable
// - Completion clears write enable latch
// - Protected target refused, latch cleared
// - Protect level set only by status write
// - Chip erase only with level zero
// - Quad enable low: pins are protect, reset
// - Quad enable high: pins are data lines
// - Write disable plus protect low locks status
`include "fis_regs.svh"

module fis_top #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h11, // Arbitrary value
    parameter logic [7:0] MEM_DENSITY = 8'h22, // Arbitrary value
    parameter logic [7:0] SIGNATURE = 8'h33, // Arbitrary value
    parameter logic [7:0] WRITE_EN_OP = 8'h06,
    parameter logic [7:0] STATUS_RD_OP = 8'h05,
    parameter logic [7:0] CONFIG_RD_OP = 8'h15
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic [3:0] data_oe,
    // Mode and config from device core
    input wire logic four_line_command_mode,
    input wire logic [7:0] config_byte,
    // Program, erase and status-write requests
    input wire logic pe_req,
    input wire logic pe_chip,
    input wire logic pe_protected,
    input wire logic sw_req,
    input wire logic [7:0] sw_data,
    input wire logic op_done,
    output logic pe_go,
    output logic sw_go,
    output logic [7:0] status_byte
);
    logic s_cs_n;
    logic s_sclk;
    logic [3:0] s_io;
    logic sclk_prev_reg;
    logic rise;
    logic fall;

    // Reset to idle pin levels: deselected, protect and reset high
    fis_sync #(.WIDTH(6), .RST_VAL(6'h2c)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d_in({cs_n, sclk, data_in}),
        .d_out({s_cs_n, s_sclk, s_io})
    );

    assign rise = s_sclk & ~sclk_prev_reg;
    assign fall = ~s_sclk & sclk_prev_reg;

    fis_pkg::fis_state_t state_reg, state_next;
    fis_pkg::fis_src_t src_reg, src_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] opc_reg, opc_next;
    logic [7:0] addr_reg, addr_next;
    logic [2:0] pos_reg, pos_next;
    logic [1:0] idx_reg, idx_next;
    logic quad_reg, quad_next;
    logic [3:0] out_reg, out_next;
    logic [3:0] oe_reg, oe_next;
    logic [7:0] status_reg, status_next;
    logic pe_go_reg, pe_go_next;
    logic sw_go_reg, sw_go_next;
    logic wen_pulse;
    logic pin_reset;
    logic hardware_protection_mode;
    logic [7:0] cur_byte;
    logic last_bit;

    function automatic logic [7:0] fis_shift(input logic [7:0] v,
        input logic [3:0] io, input logic quad);
        fis_shift = quad ? {v[3:0], io} : {v[6:0], io[0]};
    endfunction : fis_shift

    function automatic logic [7:0] fis_pick(input fis_pkg::fis_src_t src,
        input logic [1:0] idx, input logic swap);
        case (src)
            fis_pkg::SRC_ID3:
                fis_pick = (idx == 2'd0) ? MAKER_ID :
                    (idx == 2'd1) ? MEM_TYPE : MEM_DENSITY;
            fis_pkg::SRC_SIG: fis_pick = SIGNATURE;
            fis_pkg::SRC_MAKER:
                fis_pick = (idx[0] ^ swap) ? SIGNATURE : MAKER_ID;
            fis_pkg::SRC_STATUS: fis_pick = status_reg;
            fis_pkg::SRC_CONFIG: fis_pick = config_byte;
            default: fis_pick = 8'h00;
        endcase
    endfunction : fis_pick

    function automatic logic [1:0] fis_nbytes(input fis_pkg::fis_src_t src);
        case (src)
            fis_pkg::SRC_ID3: fis_nbytes = 2'd3;
            fis_pkg::SRC_MAKER: fis_nbytes = 2'd2;
            default: fis_nbytes = 2'd1;
        endcase
    endfunction : fis_nbytes

    // Shared pins act as reset and protect only while quad is off
    assign pin_reset = ~status_reg[`FIS_SR_QUAD] & ~s_io[3];
    assign hardware_protection_mode = status_reg[`FIS_SR_LOCK]
        & ~status_reg[`FIS_SR_QUAD] & ~s_io[2];
    assign cur_byte = fis_pick(src_reg, idx_reg, addr_reg[0]);
    assign last_bit = quad_reg ? (pos_reg == 3'd1) : (pos_reg == 3'd7);

    // Link side
    always_comb
    begin
        state_next = state_reg;
        src_next = src_reg;
        cnt_next = cnt_reg;
        opc_next = opc_reg;
        addr_next = addr_reg;
        pos_next = pos_reg;
        idx_next = idx_reg;
        quad_next = quad_reg;
        out_next = out_reg;
        oe_next = oe_reg;
        wen_pulse = 1'b0;
        if (s_cs_n || pin_reset)
        begin
            state_next = fis_pkg::ST_IDLE;
            oe_next = 4'h0;
            out_next = 4'h0;
            cnt_next = 5'd0;
        end
        else
        begin
            case (state_reg)
                fis_pkg::ST_IDLE:
                begin
                    state_next = fis_pkg::ST_CMD;
                    cnt_next = 5'd0;
                    // Four-line frames only with quad enabled
                    quad_next = four_line_command_mode
                        & status_reg[`FIS_SR_QUAD];
                end
                fis_pkg::ST_CMD:
                    if (rise)
                    begin
                        opc_next = fis_shift(opc_reg, s_io,
                            quad_reg);
                        cnt_next = cnt_reg + 5'd1;
                        pos_next = 3'd0;
                        idx_next = 2'd0;
                        if (cnt_next == (quad_reg ? `FIS_QUAD_CMD_CLKS
                            : `FIS_SPI_CMD_CLKS))
                        begin
                            cnt_next = 5'd0;
                            state_next = fis_pkg::ST_DROP;
                            if (opc_next == WRITE_EN_OP)
                                wen_pulse = 1'b1;
                            else if (opc_next == STATUS_RD_OP)
                            begin
                                state_next = fis_pkg::ST_OUT;
                                src_next = fis_pkg::SRC_STATUS;
                            end
                            else if (opc_next == CONFIG_RD_OP)
                            begin
                                state_next = fis_pkg::ST_OUT;
                                src_next = fis_pkg::SRC_CONFIG;
                            end
                            else if (opc_next == `FIS_OP_QUAD_ID && quad_reg)
                            begin
                                state_next = fis_pkg::ST_OUT;
                                src_next = fis_pkg::SRC_ID3;
                            end
                            else if (opc_next == `FIS_OP_ID3 && !quad_reg
                                && !status_reg[`FIS_SR_BUSY])
                            begin
                                state_next = fis_pkg::ST_OUT;
                                src_next = fis_pkg::SRC_ID3;
                            end
                            else if (opc_next == `FIS_OP_SIG)
                            begin
                                state_next = fis_pkg::ST_SKIP;
                                src_next = fis_pkg::SRC_SIG;
                            end
                            else if (opc_next == `FIS_OP_MAKER && !quad_reg)
                            begin
                                state_next = fis_pkg::ST_SKIP;
                                src_next = fis_pkg::SRC_MAKER;
                            end
                        end
                    end
                fis_pkg::ST_SKIP:
                    if (rise)
                    begin
                        addr_next = fis_shift(addr_reg, s_io, quad_reg);
                        cnt_next = cnt_reg + 5'd1;
                        if (cnt_next == (quad_reg ? `FIS_QUAD_SKIP_CLKS
                            : `FIS_SPI_SKIP_CLKS))
                            state_next = fis_pkg::ST_OUT;
                    end
                fis_pkg::ST_OUT:
                    if (fall)
                    begin
                        // MSB first, live value on every pass
                        if (quad_reg)
                        begin
                            out_next = pos_reg[0] ? cur_byte[3:0]
                                : cur_byte[7:4];
                            oe_next = 4'hf;
                        end
                        else
                        begin
                            out_next = {2'b00, cur_byte[3'd7 - pos_reg],
                                1'b0};
                            oe_next = 4'b0010;
                        end
                        pos_next = last_bit ? 3'd0 : pos_reg + 3'd1;
                        if (last_bit)
                            idx_next = (idx_reg + 2'd1 == fis_nbytes(src_reg))
                                ? 2'd0 : idx_reg + 2'd1;
                    end
                fis_pkg::ST_DROP: ;
                default: state_next = fis_pkg::ST_IDLE;
            endcase
        end
    end

    // Status byte and operation start
    always_comb
    begin
        status_next = status_reg;
        pe_go_next = 1'b0;
        sw_go_next = 1'b0;
        if (op_done)
        begin
            status_next[`FIS_SR_BUSY] = 1'b0;
            status_next[`FIS_SR_LATCH] = 1'b0;
        end
        if (pe_req && !status_reg[`FIS_SR_BUSY]
            && status_reg[`FIS_SR_LATCH])
        begin
            if (pe_protected || (pe_chip
                && status_reg[`FIS_SR_BP_HI:`FIS_SR_BP_LO] != 4'h0))
                status_next[`FIS_SR_LATCH] = 1'b0;
            else
            begin
                pe_go_next = 1'b1;
                status_next[`FIS_SR_BUSY] = 1'b1;
            end
        end
        else if (sw_req && !status_reg[`FIS_SR_BUSY]
            && status_reg[`FIS_SR_LATCH]
            && !hardware_protection_mode)
        begin
            status_next[7:2] = sw_data[7:2];
            sw_go_next = 1'b1;
            status_next[`FIS_SR_BUSY] = 1'b1;
        end
        if (pin_reset)
            status_next[`FIS_SR_LATCH] = 1'b0;
        // Set beats any clear in the same cycle
        if (wen_pulse)
            status_next[`FIS_SR_LATCH] = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sclk_prev_reg <= 1'b0;
            state_reg <= fis_pkg::ST_IDLE;
            src_reg <= fis_pkg::SRC_STATUS;
            cnt_reg <= 5'd0;
            opc_reg <= 8'h00;
            addr_reg <= 8'h00;
            pos_reg <= 3'd0;
            idx_reg <= 2'd0;
            quad_reg <= 1'b0;
            out_reg <= 4'h0;
            oe_reg <= 4'h0;
            status_reg <= `FIS_SR_RESET;
            pe_go_reg <= 1'b0;
            sw_go_reg <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= s_sclk;
            state_reg <= state_next;
            src_reg <= src_next;
            cnt_reg <= cnt_next;
            opc_reg <= opc_next;
            addr_reg <= addr_next;
            pos_reg <= pos_next;
            idx_reg <= idx_next;
            quad_reg <= quad_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            status_reg <= status_next;
            pe_go_reg <= pe_go_next;
            sw_go_reg <= sw_go_next;
        end
    end

    assign data_out = out_reg;
    assign data_oe = oe_reg;
    assign pe_go = pe_go_reg;
    assign sw_go = sw_go_reg;
    assign status_byte = status_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_out_step;
        fall && state_reg == fis_pkg::ST_OUT && !s_cs_n && !pin_reset;
    endsequence

    property p_busy_with_go;
        pe_go |-> status_byte[0] && !$past(status_byte[0]);
    endproperty
    a_busy_with_go: assert property (p_busy_with_go)
        else $error("busy flag not raised with start");

    property p_need_wel;
        pe_req && !status_byte[1] |=> !pe_go;
    endproperty
    a_need_wel: assert property (p_need_wel)
        else $error("program started without write enable");

    property p_done_clears;
        op_done && !wen_pulse |=> !status_byte[0] && !status_byte[1];
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("completion left busy or latch set");

    property p_protected;
        pe_req && pe_protected && status_byte[1] && !status_byte[0]
            && !wen_pulse |=> !pe_go && !status_byte[1];
    endproperty
    a_protected: assert property (p_protected)
        else $error("protected target not refused");

    property p_chip_bp;
        pe_req && pe_chip && status_byte[5:2] != 4'h0 |=> !pe_go;
    endproperty
    a_chip_bp: assert property (p_chip_bp)
        else $error("chip erase ran with protect level set");

    property p_protect_lock;
        sw_req && hardware_protection_mode && !op_done
            |=> !sw_go && $stable(status_byte[7:2]);
    endproperty
    a_protect_lock: assert property (p_protect_lock)
        else $error("status write accepted while locked");

    property p_deselect;
        s_cs_n |=> data_oe == 4'h0 && state_reg == fis_pkg::ST_IDLE;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("output still driven after deselect");

    property p_quad_lines;
        data_oe[3:2] != 2'b00 |-> quad_reg;
    endproperty
    a_quad_lines: assert property (p_quad_lines)
        else $error("upper lines driven outside quad frame");

    property p_status_bit;
        s_out_step ##0 (src_reg == fis_pkg::SRC_STATUS && !quad_reg)
            |=> data_out[1] == $past(status_reg[3'd7 - pos_reg])
            && data_oe == 4'b0010;
    endproperty
    a_status_bit: assert property (p_status_bit)
        else $error("wrong status bit on serial output");

    property p_first_out;
        s_out_step ##0 (pos_reg == 3'd0 && idx_reg == 2'd0)
            |=> data_oe != 4'h0 ##1 data_oe != 4'h0 || s_cs_n;
    endproperty
    a_first_out: assert property (p_first_out)
        else $error("data not driven after command");
endmodule : fis_top

// file: tb/fis_host.sv
module fis_host (
    // Clock
    input wire logic sys_clk,
    // Link pins
    output logic cs_n,
    output logic sclk,
    output logic [3:0] drv,
    output logic [3:0] val,
    input wire logic [3:0] line,
    input wire logic [3:0] oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] oe_seen;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        drv = 4'h0;
        val = 4'h0;
        oe_seen = 4'h0;
    end
    // Mode 0 frame; clock stands low outside frames
    task automatic frame(input bit quad, input logic [31:0] tx,
        input int ntx, input int nrx, output logic [63:0] rx);
        logic [31:0] sh;
        sh = tx;
        rx = '0;
        @(posedge sys_clk) cs_n <= 1'b0;
        for (int k = 0; k < ntx + nrx; k++)
        begin
            @(posedge sys_clk);
            drv <= (k >= ntx) ? 4'h0 : (quad ? 4'hf : 4'h1);
            val <= quad ? sh[31:28] : {3'b000, sh[31]};
            sh = quad ? sh << 4 : sh << 1;
            repeat (3) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            // Sample late in the high phase, data is settled
            if (k >= ntx)
                rx = quad ? {rx[59:0], line} : {rx[62:0], line[1]};
            oe_seen = oe;
            sclk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        drv <= 4'h0;
        repeat (6) @(posedge sys_clk);
    endtask : frame
    // Pull chosen lines low outside frames
    task automatic pull_low(input logic [3:0] mask);
        @(posedge sys_clk);
        drv <= mask;
        val <= 4'h0;
        // Let the pin synchroniser settle before the next request
        repeat (3) @(posedge sys_clk);
    endtask : pull_low
endmodule : fis_host

// file: tb/tb_fis_top.sv
module tb_fis_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MK = 8'h3c; // Arbitrary value
    localparam logic [7:0] TY = 8'h47; // Arbitrary value
    localparam logic [7:0] DN = 8'h81; // Arbitrary value
    localparam logic [7:0] SG = 8'h6e; // Arbitrary value
    logic sys_clk, rst, cs_n, sclk, four_line_command_mode, tog;
    logic pe_req, pe_chip, pe_protected, sw_req, op_done, pe_go, sw_go;
    logic [3:0] data_out, data_oe, drv, val, line, idle;
    logic [7:0] config_byte, sw_data, status_byte, sr, c;
    logic [63:0] rx;
    int fails, num_checks, cyc;

    // Wire level: device, then host, then idle pattern or pull-up
    assign idle = {2'b11, tog, ~tog};
    assign line = (data_oe & data_out) | (~data_oe & drv & val)
        | (~data_oe & ~drv & idle);

    fis_top #(.MAKER_ID(MK), .MEM_TYPE(TY), .MEM_DENSITY(DN),
        .SIGNATURE(SG)) fis_top_inst (.sys_clk, .rst, .cs_n, .sclk,
        .data_in(line), .data_out, .data_oe, .four_line_command_mode,
        .config_byte, .pe_req, .pe_chip, .pe_protected, .sw_req,
        .sw_data, .op_done, .pe_go, .sw_go, .status_byte);
    fis_host fis_host_inst (.sys_clk, .cs_n, .sclk, .drv, .val, .line,
        .oe(data_oe));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        tog <= ~tog;
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [63:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Byte stream of n bytes cycling through the first per of pat
    function automatic logic [63:0] rep(input logic [23:0] pat,
        input int per, input int n);
        logic [7:0] q[$];
        logic [63:0] r;
        q = {pat[23:16], pat[15:8], pat[7:0]};
        r = '0;
        for (int i = 0; i < n; i++)
            r = {r[55:0], q[i % per]};
        return r;
    endfunction : rep
    task automatic rd(input bit quad, input logic [31:0] tx, input int ntx,
        input int n, input logic [63:0] exp);
        fis_host_inst.frame(quad, tx, ntx, quad ? 2 * n : 8 * n, rx);
        chk("stream", exp, rx);
        chk("data_oe", quad ? 4'hf : 4'h2, fis_host_inst.oe_seen);
    endtask : rd
    task automatic st(input bit quad);
        rd(quad, 32'h05000000, quad ? 2 : 8, 2, rep({sr, 16'h0}, 1, 2));
        chk("status_byte", sr, status_byte);
    endtask : st
    task automatic wr_en(input bit quad);
        fis_host_inst.frame(quad, 32'h06000000, quad ? 2 : 8, 0, rx);
        sr = sr | 8'h02;
    endtask : wr_en
    task automatic pe(input logic chip, prot, go);
        @(posedge sys_clk);
        pe_req <= 1'b1;
        pe_chip <= chip;
        pe_protected <= prot;
        @(posedge sys_clk);
        pe_req <= 1'b0;
        #1;
        chk("pe_go", go, pe_go);
        sr = go ? (sr | 8'h01) : (sr & 8'hfd);
    endtask : pe
    task automatic sw(input logic [7:0] d, input logic go);
        @(posedge sys_clk);
        sw_data <= d;
        sw_req <= 1'b1;
        @(posedge sys_clk);
        sw_req <= 1'b0;
        #1;
        chk("sw_go", go, sw_go);
        if (go)
            sr = {d[7:2], sr[1:0]} | 8'h01;
    endtask : sw
    task automatic done();
        @(posedge sys_clk);
        op_done <= 1'b1;
        @(posedge sys_clk);
        op_done <= 1'b0;
        @(posedge sys_clk);
        #1;
        sr = sr & 8'hfc;
        chk("status_byte", sr, status_byte);
    endtask : done

    initial
    begin
        rst = 1'b1;
        tog = 1'b0;
        four_line_command_mode = 1'b0;
        config_byte = 8'h00;
        {pe_req, pe_chip, pe_protected, sw_req, op_done} = 5'h00;
        sw_data = 8'h00;
        sr = 8'h00;
        fails = 0;
        num_checks = 0;
        cyc = 0;
        void'($urandom(32'h0db7));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("status_byte", 8'h00, status_byte);
        st(0);
        pe(0, 0, 0);
        wr_en(0);
        st(0);
        pe(0, 0, 1);
        // Identification read is not decoded while busy
        fis_host_inst.frame(0, 32'h9f000000, 8, 8, rx);
        chk("data_oe", 4'h0, fis_host_inst.oe_seen);
        st(0);
        done();
        st(0);
        wr_en(0);
        sw(8'h84, 1);
        done();
        wr_en(0);
        pe(1, 0, 0);
        wr_en(0);
        pe(0, 1, 0);
        st(0);
        wr_en(0);
        fis_host_inst.pull_low(4'h4);
        sw(8'h40, 0);
        fis_host_inst.pull_low(4'h8);
        repeat (6) @(posedge sys_clk);
        fis_host_inst.pull_low(4'h0);
        sr = sr & 8'hfd;
        st(0);
        wr_en(0);
        sw(8'h44, 1);
        done();
        repeat (3)
        begin
            c = 8'($urandom);
            config_byte <= c;
            rd(0, 32'h15000000, 8, 2, rep({c, 16'h0}, 1, 2));
        end
        rd(0, 32'h9f000000, 8, 6, rep({MK, TY, DN}, 3, 6));
        rd(0, 32'hab000000, 32, 2, rep({SG, 16'h0}, 1, 2));
        rd(0, 32'h90000000, 32, 4, rep({MK, SG, 8'h0}, 2, 4));
        rd(0, 32'h90000001, 32, 4, rep({SG, MK, 8'h0}, 2, 4));
        fis_host_inst.frame(0, 32'haf000000, 8, 16, rx);
        chk("data_oe", 4'h0, fis_host_inst.oe_seen);
        four_line_command_mode <= 1'b1;
        rd(1, 32'haf000000, 2, 6, rep({MK, TY, DN}, 3, 6));
        wr_en(1);
        st(1);
        rd(1, 32'h15000000, 2, 2, rep({c, 16'h0}, 1, 2));
        rd(1, 32'hab000000, 8, 2, rep({SG, 16'h0}, 1, 2));
        report_and_stop();
    end
endmodule : tb_fis_top
